// ### wdt_pkg.sv
// constants and types shared by the watchdog timer block
`default_nettype none

package wdt_pkg;

	// ==========================================================
	// register map
	localparam logic [7:0] WDT_CTRL_ADDR = 8'h21;
	localparam logic [7:0] WDT_CTRL_RESET = 8'h00;

	// ==========================================================
	// control register field positions
	localparam int WDT_SEL_LSB = 0;
	localparam int WDT_SEL_W = 3;
	localparam int WDT_ON_BIT = 3;
	localparam int WDT_UNLOCK_BIT = 4;
	localparam int WDT_RSVD_LSB = 5;
	localparam int WDT_RSVD_W = 3;

	// ==========================================================
	// timing
	// watchdog oscillator, nominal rate
	localparam int WDT_OSC_HZ = 1_000_000;
	// system clock rate
	localparam int WDT_CLK_HZ = 20_000_000;
	// system clock periods per oscillator period, must stay >= 4
	localparam int WDT_OSC_RATIO = WDT_CLK_HZ / WDT_OSC_HZ;
	// lifetime of the turn-off unlock bit, in clock cycles
	localparam logic [2:0] WDT_UNLOCK_CYCLES = 3'h4;
	// shortest timeout, in oscillator cycles (16K)
	localparam int WDT_TIMEOUT_BASE = 32'h0000_4000;
	// counter wide enough for the longest timeout (2048K)
	localparam int WDT_CNT_W = 21;

	// ==========================================================
	// control register contents
	typedef struct packed {
		logic turn_off_unlock;
		logic watchdog_on;
		logic [WDT_SEL_W-1:0] timeout_select;
	} wdt_ctrl_t;

endpackage

`default_nettype wire

// ### wdt_top.sv
// watchdog timer: control register, oscillator counter, reset request
//
// Overview of operation
// - count edges of a dedicated watchdog oscillator, not system clock.
// - the CPU restart instruction clears the watchdog count.
// - timeout without restart requests a device reset.
// - timeout is 16K oscillator cycles times two to the select value.
// - enable bit 3 runs the watchdog; zero stops it.
// - enable clears only while the unlock bit is set.
// - unlock bit 4 clears itself four clock cycles after being set.
// - bits 7..5 read zero and ignore writes.
`timescale 1ns/1ps
`default_nettype none

module wdt_top
	import wdt_pkg::*;
#(
	parameter int TIMEOUT_BASE = WDT_TIMEOUT_BASE,
	parameter int CNT_W = WDT_CNT_W
) (
	// clock, reset, enable
	input wire logic clk,
	input wire logic rst,
	input wire logic clk_en,

	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,

	// cpu restart instruction, one-cycle pulse
	input wire logic kick_instruction,

	// watchdog oscillator pin
	input wire logic wdog_osc,

	// status and reset request
	output logic wdog_running,
	output logic wdog_reset_req
);

	// ==========================================================
	// register port decode

	logic ctrl_wr;
	logic ctrl_rd;

	assign ctrl_wr = clk_en && reg_wr && (reg_addr == WDT_CTRL_ADDR);
	assign ctrl_rd = clk_en && reg_rd && (reg_addr == WDT_CTRL_ADDR);

	// ==========================================================
	// control register and unlock timer

	wdt_ctrl_t ctrl_q;
	wdt_ctrl_t ctrl_d;
	logic [2:0] ulk_cnt_q;
	logic [2:0] ulk_cnt_d;
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;

	always_comb begin
		ctrl_d = ctrl_q;
		ulk_cnt_d = ulk_cnt_q;
		rdata_d = 8'h00;

		// unlock expires on its own unless a fresh set renews it
		if (ulk_cnt_q != 3'h0) begin
			ulk_cnt_d = ulk_cnt_q - 3'h1;
		end
		if (ulk_cnt_q == 3'h1) begin
			ctrl_d.turn_off_unlock = 1'b0;
		end

		if (ctrl_wr) begin
			ctrl_d.timeout_select = reg_wdata[WDT_SEL_LSB +: WDT_SEL_W];
			if (reg_wdata[WDT_ON_BIT]) begin
				ctrl_d.watchdog_on = 1'b1;
			end else if (ctrl_q.turn_off_unlock) begin
				// a zero only lands inside the unlock window
				ctrl_d.watchdog_on = 1'b0;
			end
			// a fresh set wins over the expiry in the same cycle
			if (reg_wdata[WDT_UNLOCK_BIT]) begin
				ctrl_d.turn_off_unlock = 1'b1;
				ulk_cnt_d = WDT_UNLOCK_CYCLES;
			end
		end

		if (ctrl_rd) begin
			rdata_d = {{WDT_RSVD_W{1'b0}}, ctrl_q};
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl_q <= wdt_ctrl_t'(WDT_CTRL_RESET[4:0]);
			ulk_cnt_q <= 3'h0;
			rdata_q <= 8'h00;
		end else if (clk_en) begin
			ctrl_q <= ctrl_d;
			ulk_cnt_q <= ulk_cnt_d;
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata = rdata_q;
	assign wdog_running = ctrl_q.watchdog_on;

	// ==========================================================
	// oscillator synchroniser and edge detect
	//
	// the oscillator is slow next to clk, so sampling it is enough;
	// this only holds while clk runs at least four times faster

	logic osc_s1_q;
	logic osc_s2_q;
	logic osc_s3_q;
	logic tick;

	assign tick = osc_s2_q && !osc_s3_q;

	// ==========================================================
	// watchdog counter

	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;
	logic [CNT_W-1:0] lim_m1;
	logic fire_q;
	logic fire_d;

	// last count before timeout for the selected period
	assign lim_m1 = CNT_W'((TIMEOUT_BASE << ctrl_q.timeout_select)
		- 32'h0000_0001);

	always_comb begin
		cnt_d = cnt_q;
		fire_d = 1'b0;
		if (!ctrl_q.watchdog_on) begin
			// held at zero, so enabling starts a full period
			cnt_d = '0;
		end else if (kick_instruction) begin
			cnt_d = '0;
		end else if (tick) begin
			// >= covers a shorter period selected mid-count
			if (cnt_q >= lim_m1) begin
				cnt_d = '0;
				fire_d = 1'b1;
			end else begin
				cnt_d = cnt_q + CNT_W'(1);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			osc_s1_q <= 1'b0;
			osc_s2_q <= 1'b0;
			osc_s3_q <= 1'b0;
			cnt_q <= '0;
			fire_q <= 1'b0;
		end else if (clk_en) begin
			osc_s1_q <= wdog_osc;
			osc_s2_q <= osc_s1_q;
			osc_s3_q <= osc_s2_q;
			cnt_q <= cnt_d;
			fire_q <= fire_d;
		end
	end

	// the system reset controller turns this pulse into rst
	assign wdog_reset_req = fire_q;

	// ==========================================================
	// checks

	property p_unlock_set;
		@(posedge clk) disable iff (rst || !clk_en)
		ctrl_wr && reg_wdata[WDT_UNLOCK_BIT] |=> ctrl_q.turn_off_unlock;
	endproperty
	a_unlock_set: assert property (p_unlock_set)
		else $error("unlock bit not set by write");

	property p_unlock_drop;
		@(posedge clk) disable iff (rst || !clk_en)
		ctrl_wr && reg_wdata[WDT_UNLOCK_BIT] ##1
		(!ctrl_wr)[*4] |=> !ctrl_q.turn_off_unlock;
	endproperty
	a_unlock_drop: assert property (p_unlock_drop)
		else $error("unlock bit not cleared after four cycles");

	property p_unlock_hold;
		@(posedge clk) disable iff (rst || !clk_en)
		ctrl_wr && reg_wdata[WDT_UNLOCK_BIT] |=>
		ctrl_q.turn_off_unlock [*4];
	endproperty
	a_unlock_hold: assert property (p_unlock_hold)
		else $error("unlock bit dropped too early");

	property p_locked_stays_on;
		@(posedge clk) disable iff (rst || !clk_en)
		ctrl_wr && !reg_wdata[WDT_ON_BIT] && !ctrl_q.turn_off_unlock &&
		ctrl_q.watchdog_on |=> ctrl_q.watchdog_on;
	endproperty
	a_locked_stays_on: assert property (p_locked_stays_on)
		else $error("watchdog disabled without unlock");

	property p_unlocked_off;
		@(posedge clk) disable iff (rst || !clk_en)
		ctrl_wr && !reg_wdata[WDT_ON_BIT] && ctrl_q.turn_off_unlock
		|=> !ctrl_q.watchdog_on && !wdog_running;
	endproperty
	a_unlocked_off: assert property (p_unlocked_off)
		else $error("unlocked disable write ignored");

	property p_kick_clears;
		@(posedge clk) disable iff (rst || !clk_en)
		kick_instruction && ctrl_q.watchdog_on |=>
		cnt_q == '0 && !wdog_reset_req;
	endproperty
	a_kick_clears: assert property (p_kick_clears)
		else $error("restart did not clear count");

	property p_enable_restart;
		@(posedge clk) disable iff (rst || !clk_en)
		$rose(ctrl_q.watchdog_on) |-> cnt_q == '0;
	endproperty
	a_enable_restart: assert property (p_enable_restart)
		else $error("count not zero at enable");

	property p_timeout_fire;
		@(posedge clk) disable iff (rst || !clk_en)
		ctrl_q.watchdog_on && !kick_instruction && tick &&
		cnt_q == lim_m1 |=> wdog_reset_req ##1 !wdog_reset_req;
	endproperty
	a_timeout_fire: assert property (p_timeout_fire)
		else $error("timeout did not raise one reset pulse");

	property p_fire_cause;
		@(posedge clk) disable iff (rst || !clk_en)
		// a pulse held over a frozen cycle has no cause in that cycle
		$past(clk_en) && wdog_reset_req |-> $past(ctrl_q.watchdog_on) &&
		$past(cnt_q) >= $past(lim_m1) && cnt_q == '0;
	endproperty
	a_fire_cause: assert property (p_fire_cause)
		else $error("reset pulse before the selected timeout");

	property p_tick_only;
		@(posedge clk) disable iff (rst || !clk_en)
		ctrl_q.watchdog_on && !tick && !kick_instruction
		|=> $stable(cnt_q);
	endproperty
	a_tick_only: assert property (p_tick_only)
		else $error("count moved without an oscillator edge");

	property p_rsvd_zero;
		@(posedge clk) disable iff (rst || !clk_en)
		ctrl_rd |=> reg_rdata[WDT_RSVD_LSB +: WDT_RSVD_W] == '0 &&
		reg_rdata[WDT_ON_BIT] == $past(ctrl_q.watchdog_on);
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero)
		else $error("reserved bits not zero or bad readback");

	property p_off_quiet;
		@(posedge clk) disable iff (rst || !clk_en)
		!ctrl_q.watchdog_on |=>
		cnt_q == '0 && !wdog_reset_req;
	endproperty
	a_off_quiet: assert property (p_off_quiet)
		else $error("stopped watchdog counted or fired");

	property p_tick_count;
		@(posedge clk) disable iff (rst || !clk_en)
		ctrl_q.watchdog_on && !kick_instruction && tick && cnt_q < lim_m1
		|=> cnt_q == $past(cnt_q) + CNT_W'(1);
	endproperty
	a_tick_count: assert property (p_tick_count)
		else $error("oscillator edge not counted");

	property p_enable_by_write;
		@(posedge clk) disable iff (rst || !clk_en)
		$rose(ctrl_q.watchdog_on) |->
		$past(ctrl_wr) && $past(reg_wdata[WDT_ON_BIT]);
	endproperty
	a_enable_by_write: assert property (p_enable_by_write)
		else $error("watchdog enabled without a write");

	property p_unlock_by_write;
		@(posedge clk) disable iff (rst || !clk_en)
		$rose(ctrl_q.turn_off_unlock) |->
		$past(ctrl_wr) && $past(reg_wdata[WDT_UNLOCK_BIT]);
	endproperty
	a_unlock_by_write: assert property (p_unlock_by_write)
		else $error("unlock bit set without a write");

	property p_select_write;
		@(posedge clk) disable iff (rst || !clk_en)
		ctrl_wr |=> ctrl_q.timeout_select ==
		$past(reg_wdata[WDT_SEL_LSB +: WDT_SEL_W]);
	endproperty
	a_select_write: assert property (p_select_write)
		else $error("timeout select not written");

endmodule

`default_nettype wire

// ### tb.sv
// self-checking testbench for the watchdog timer block
`timescale 1ns/1ps
`default_nettype none

module tb;
	import wdt_pkg::*;

	// ==========================================================
	// design hookup; short base keeps the longest timeout brief
	localparam int BASE = 4;
	localparam logic [7:0] A = WDT_CTRL_ADDR;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic clk_en = 1'b1;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic kick = 1'b0;
	logic osc = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic [7:0] rdata;
	logic running;
	logic bite;
	logic [2:0] ph = 3'h0;
	int fail_count = 0;
	int n_tests = 0;
	int cycles = 0;
	int bites = 0;
	int b0;

	wdt_top #(.TIMEOUT_BASE(BASE)) dut_u (
		.clk(clk), .rst(rst), .clk_en(clk_en),
		.reg_addr(addr), .reg_wdata(wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(rdata),
		.kick_instruction(kick), .wdog_osc(osc),
		.wdog_running(running), .wdog_reset_req(bite)
	);

	// ==========================================================
	// clock, oscillator at one eighth of clk, pulse count, timeout
	always #25 clk = ~clk;

	always @(posedge clk) begin
		cycles <= cycles + 1;
		ph <= ph + 3'h1;
		osc <= ph[2];
		if (bite === 1'b1) begin
			bites <= bites + 1;
		end
	end

	always @(posedge clk) begin
		if (cycles == 40000) begin
			fail_count = fail_count + 1;
			complete_run();
		end
	end

	// ==========================================================
	// access tasks
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_tests = n_tests + 1;
		if (seen !== exp) begin
			fail_count = fail_count + 1;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	// a gap cycle after each write keeps strobes one cycle long
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk(rdata, exp);
		@(posedge clk);
	endtask

	// cycles until the next reset request must fall in lo..hi
	task automatic bite_in(input int lo, input int hi);
		int n;
		int c0;
		n = 0;
		c0 = bites;
		while (bites == c0 && n < hi + 2) begin
			@(posedge clk);
			n = n + 1;
		end
		chk({7'h00, (n >= lo && n <= hi)}, 8'h01);
	endtask

	task automatic complete_run();
		$display("comparisons %0d, mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// ==========================================================
	// test sequence
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd(A, WDT_CTRL_RESET);
		chk({7'h00, running}, 8'h00);
		$display("test reset values done");
		wr(A, 8'hff);
		rd(A, 8'h1f);
		repeat (4) @(posedge clk);
		rd(A, 8'h0f);
		wr(A, 8'h00);
		rd(A, 8'h08);
		chk({7'h00, running}, 8'h01);
		$display("test register fields done");
		// unlock then clear in the last cycle of the window
		wr(A, 8'h18);
		repeat (2) @(posedge clk);
		wr(A, 8'h00);
		rd(A, 8'h00);
		wr(A, 8'h08);
		wr(A, 8'h18);
		repeat (3) @(posedge clk);
		wr(A, 8'h00);
		rd(A, 8'h08);
		wr(A, 8'h18);
		wr(A, 8'h00);
		// let a pulse launched just before the disable be counted first
		@(posedge clk);
		b0 = bites;
		repeat (600) @(posedge clk);
		chk({7'h00, running}, 8'h00);
		chk(8'(bites - b0), 8'h00);
		$display("test disable window done");
		for (int s = 0; s < 8; s++) begin
			wr(A, {5'h01, s[2:0]});
			bite_in((BASE << s) * 8 - 8, (BASE << s) * 8 + 8);
			wr(A, 8'h18);
			wr(A, 8'h00);
		end
		$display("test timeout select done");
		wr(A, 8'h08);
		b0 = bites;
		repeat (12) begin
			kick <= 1'b1;
			@(posedge clk);
			kick <= 1'b0;
			repeat (15) @(posedge clk);
		end
		chk(8'(bites - b0), 8'h00);
		kick <= 1'b1;
		@(posedge clk);
		kick <= 1'b0;
		bite_in(24, 40);
		$display("test restart done");
		// a frozen block ignores the oscillator and the register port
		kick <= 1'b1;
		@(posedge clk);
		kick <= 1'b0;
		clk_en <= 1'b0;
		b0 = bites;
		wr(A, 8'h18);
		wr(A, 8'h00);
		repeat (200) @(posedge clk);
		chk(8'(bites - b0), 8'h00);
		clk_en <= 1'b1;
		rd(A, 8'h08);
		// stale synchroniser state may add one early edge on resume
		bite_in(16, 40);
		$display("test clock enable done");
		// unmapped address neither unlocks nor reads back
		wr(8'h22, 8'h18);
		wr(A, 8'h00);
		rd(A, 8'h08);
		rd(8'h22, 8'h00);
		$display("test unmapped address done");
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rd(A, WDT_CTRL_RESET);
		chk({7'h00, running}, 8'h00);
		$display("test mid-run reset done");
		complete_run();
	end
endmodule

`default_nettype wire
